/* File: bench/pev_host.sv */
// Host controller model, an I2C master on open-drain lines.
`timescale 1ns/1ps
module pev_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic [2:0] ack;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // Data moves only well inside a clock phase, so no edge of it can look like a start or stop.
    task automatic hp(input logic s, input logic d);
        scl_o <= s;
        repeat (5) @(posedge clk_i);
        sda_o <= d;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic xfer(input logic [8:0] tx, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            hp(1'b0, tx[i]);
            hp(1'b1, tx[i]);
            r[i] = sda_i;
        end
    endtask
    task automatic access(input logic [6:0] dev, input logic [7:0] ptr, input logic rd,
        input logic [7:0] wd, output logic [7:0] rv);
        logic [8:0] r;
        hp(1'b0, 1'b1);
        hp(1'b1, 1'b0);
        xfer({dev, 2'b01}, r);
        ack[2] = r[0];
        xfer({ptr, 1'b1}, r);
        ack[1] = r[0];
        if (rd) begin
            hp(1'b0, 1'b1);
            hp(1'b1, 1'b0);
            xfer({dev, 2'b11}, r);
            ack[0] = r[0];
            xfer(9'h1FF, r);
        end else begin
            xfer({wd, 1'b1}, r);
            ack[0] = r[0];
        end
        rv = r[8:1];
        hp(1'b0, 1'b0);
        hp(1'b1, 1'b1);
    endtask
endmodule

/* File: bench/pev_regs_tb_top.sv */
// Self-checking bench for the event and external enable register bank.
`timescale 1ns/1ps
module pev_regs_tb_top;
    import pev_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, wake_i = 1'b0, buck4_ldo_mode_i = 1'b0;
    logic input_overvolt_i = 1'b0, overtemp_i = 1'b0, supply_monitor_ok_i = 1'b0;
    logic [5:0] rail_power_bad_i = 6'h00, exception_i = 6'h00, rail_power_good_i = 6'h00;
    logic [3:0] enable_pin_i = 4'h0;
    logic scl_i, sda_i, sda_o, sda_oe_o, sda_m, reset_out_n_o, interrupt_out_n_o;
    logic external_enable_out1_o, external_enable_out2_o, input_overvolt_warn_level_o;
    pev_ramp_s ramp_o;
    logic [7:0] v;
    logic [7:0] dflt [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h07, 8'hC0, 8'hC0, 8'h00, 8'h55, 8'h00};
    int n_mismatch = 0;
    int n_compared = 0;
    assign sda_i = sda_m & ~sda_oe_o;
    always #4 clk_i = ~clk_i;
    pev_regs #(.STEP_CYCLES(8)) dut (.clk_i, .rstn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
        .rail_power_bad_i, .input_overvolt_i, .overtemp_i, .exception_i, .rail_power_good_i,
        .supply_monitor_ok_i, .enable_pin_i, .wake_i, .buck4_ldo_mode_i, .reset_out_n_o,
        .interrupt_out_n_o, .external_enable_out1_o, .external_enable_out2_o,
        .input_overvolt_warn_level_o, .ramp_o);
    pev_host host (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(sda_m));
    ////////////////////////////////////////////////////////////////
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [59:0] seen, input logic [59:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(I2C_ADDR_DEF, a, 1'b0, d, v);
        chk(host.ack, 3'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.access(I2C_ADDR_DEF, a, 1'b1, 8'h00, v);
        chk(v, e);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        // Roughly twice the expected length of all tests.
        #500000;
        n_mismatch++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        w(20);
        rstn_i <= 1'b1;
        w(4);
        chk(ramp_o, {6{RAMP_250}});
        for (int i = 0; i < 11; i++) rdc(8'h10 + 8'(i), dflt[i]);
        rdc(8'h40, 8'h00);
        wr(A_WARN, 8'h80);
        chk(input_overvolt_warn_level_o, 1'b1);
        wr(A_SST0, 8'hE4);
        wr(A_SST1, 8'hFF);
        rdc(A_SST1, 8'hC0);
        chk(ramp_o, {RAMP_750, RAMP_500, RAMP_250, RAMP_125, RAMP_500, RAMP_500});
        buck4_ldo_mode_i <= 1'b1;
        w(3);
        chk(ramp_o.b4, RAMP_250);
        $display("registers test done");
        rail_power_bad_i <= 6'h3F;
        overtemp_i <= 1'b1;
        w(6);
        chk(reset_out_n_o, 1'b0);
        wr(A_RSTMASK, 8'hFF);
        chk(reset_out_n_o, 1'b1);
        wr(A_RSTMASK, 8'hFE);
        chk(reset_out_n_o, 1'b0);
        wr(A_RSTMASK, 8'hFF);
        exception_i <= 6'h01;
        w(6);
        chk(interrupt_out_n_o, 1'b0);
        wr(A_CLR, 8'h04);
        rdc(A_CLR, 8'h04);
        exception_i <= 6'h00;
        wr(A_CLR, 8'hFC);
        rdc(A_CLR, 8'h00);
        chk(interrupt_out_n_o, 1'b1);
        wr(A_IMASK, 8'hFC);
        exception_i <= 6'h01;
        w(6);
        chk(interrupt_out_n_o, 1'b1);
        rdc(A_CLR, 8'h00);
        $display("event test done");
        wr(A_TRIG1, 8'h80);
        wr(A_HOST, 8'h01);
        chk(external_enable_out1_o, 1'b1);
        wr(A_RSTMASK, 8'hFE);
        chk(external_enable_out1_o, 1'b0);
        wr(A_RSTMASK, 8'hFF);
        wr(A_HOST, 8'h00);
        chk(external_enable_out1_o, 1'b0);
        wr(A_DELAY, 8'h02);
        wr(A_TRIG2, 8'h46);
        enable_pin_i <= 4'h8;
        w(16);
        chk(external_enable_out2_o, 1'b0);
        w(12);
        chk(external_enable_out2_o, 1'b1);
        wr(A_TRIG1, 8'h38);
        supply_monitor_ok_i <= 1'b1;
        w(12);
        chk(external_enable_out1_o, 1'b1);
        wr(A_TRIG1, 8'hC0);
        wr(A_SLOT1, 8'h03);
        wake_i <= 1'b1;
        w(18);
        chk(external_enable_out1_o, 1'b0);
        w(10);
        chk(external_enable_out1_o, 1'b1);
        $display("enable test done");
        finish_test();
    end
endmodule

/* File: logic/pev_ext_out.sv */
// One external enable output: trigger selection and rise delay.
`timescale 1ns/1ps
module pev_ext_out #(parameter int STEP_CYCLES = pev_pkg::STEP_CYC) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic [7:0] cfg_i,
    input wire logic [4:0] slot_i,
    input wire logic [3:0] delay_i,
    input wire logic [1:0] host_i,
    input wire logic [7:0] good_i,
    input wire logic [3:0] pin_i,
    input wire logic [4:0] slot_now_i,
    input wire logic wake_start_i,
    output logic out_o
);
    import pev_pkg::*;
    localparam int CW = $clog2(STEP_CYCLES + 1);
    pev_src_e src;
    logic trig, trig_q, slot_hit, busy;
    logic [CW-1:0] cyc;
    logic [3:0] steps;

    assign src = pev_src_e'(cfg_i[SRC_LSB+:2]);

    always_comb begin
        case (src)
            SRC_GOOD: trig = good_i[cfg_i[GOOD_LSB+:3]];
            SRC_PIN: trig = pin_i[cfg_i[PIN_LSB+:2]];
            SRC_SLOT: trig = slot_hit;
            default: trig = 1'b0;
        endcase
    end

    // A slot stays reached until the next wake-up sequence starts.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slot_hit <= 1'b0;
        end else if (wake_start_i) begin
            slot_hit <= 1'b0;
        end else if (slot_i != 5'h00 && slot_now_i == slot_i) begin
            slot_hit <= 1'b1;
        end
    end

    // Gating the edge detector by the enable lets a trigger held high across release still count.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig && en_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_o <= 1'b0;
            busy <= 1'b0;
            cyc <= '0;
            steps <= 4'h0;
        end else if (!en_i) begin
            out_o <= 1'b0;
            busy <= 1'b0;
        end else if (src == SRC_HOST) begin
            out_o <= (host_i == HOST_HIGH);
            busy <= 1'b0;
        end else if (!trig) begin
            out_o <= 1'b0;
            busy <= 1'b0;
        end else if (!trig_q) begin
            busy <= 1'b1;
            cyc <= '0;
            steps <= 4'h0;
        end else if (busy) begin
            if (steps == delay_i) begin
                out_o <= 1'b1;
                busy <= 1'b0;
            end else if (cyc == CW'(STEP_CYCLES - 1)) begin
                cyc <= '0;
                steps <= steps + 4'h1;
            end else begin
                cyc <= cyc + 1'b1;
            end
        end
    end
endmodule

/* File: logic/pev_i2c.sv */
// Byte-wide I2C target with a register pointer and auto increment.
`timescale 1ns/1ps
module pev_i2c #(parameter logic [6:0] DEV_ADDR = pev_pkg::I2C_ADDR_DEF) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rdata_i,
    output logic sda_oe_o,
    output logic [7:0] ptr_o,
    output pev_pkg::pev_wr_s wr_o
);
    import pev_pkg::*;
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_PTR, ST_WR, ST_RD} pev_i2c_e;
    pev_i2c_e state;
    logic scl_q, sda_q, ack_ph;
    logic [3:0] bits;
    logic [7:0] sh;
    wire logic rise = scl_i && !scl_q;
    wire logic fall = !scl_i && scl_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            bits <= 4'h0;
            sh <= 8'h00;
            ack_ph <= 1'b0;
            sda_oe_o <= 1'b0;
            ptr_o <= 8'h00;
            wr_o <= '0;
        end else begin
            wr_o.en <= 1'b0;
            if (scl_i && scl_q && sda_q && !sda_i) begin
                state <= ST_DEV;
                bits <= 4'h0;
                ack_ph <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (scl_i && scl_q && !sda_q && sda_i) begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (rise) begin
                if (bits < 4'h8) begin
                    sh <= {sh[6:0], sda_i};
                    bits <= bits + 4'h1;
                end else if (state == ST_RD && sda_i) begin
                    state <= ST_IDLE;
                end
            end else if (fall) begin
                if (bits == 4'h8 && !ack_ph) begin
                    ack_ph <= 1'b1;
                    sda_oe_o <= state inside {ST_DEV, ST_PTR, ST_WR} && (state != ST_DEV || sh[7:1] == DEV_ADDR);
                    case (state)
                        ST_DEV: state <= (sh[7:1] != DEV_ADDR) ? ST_IDLE : sh[0] ? ST_RD : ST_PTR;
                        ST_PTR: begin
                            ptr_o <= sh;
                            state <= ST_WR;
                        end
                        ST_WR: begin
                            wr_o <= '{en: 1'b1, addr: ptr_o, data: sh};
                            ptr_o <= ptr_o + 8'h01;
                        end
                        default: ;
                    endcase
                end else if (ack_ph) begin
                    ack_ph <= 1'b0;
                    bits <= 4'h0;
                    sh <= (state == ST_RD) ? rdata_i : sh;
                    sda_oe_o <= (state == ST_RD) && !rdata_i[7];
                    if (state == ST_RD) begin
                        ptr_o <= ptr_o + 8'h01;
                    end
                end else begin
                    sda_oe_o <= (state == ST_RD) && !sh[7];
                end
            end
        end
    end
endmodule

/* File: logic/pev_pkg.sv */
// Shared constants, types and helpers for the event and external enable register bank.
package pev_pkg;
    localparam logic [7:0] A_WARN = 8'h10;
    localparam logic [7:0] A_RSTMASK = 8'h11;
    localparam logic [7:0] A_CLR = 8'h12;
    localparam logic [7:0] A_IMASK = 8'h13;
    localparam logic [7:0] A_SLOT1 = 8'h14;
    localparam logic [7:0] A_SLOT2 = 8'h15;
    localparam logic [7:0] A_TRIG1 = 8'h16;
    localparam logic [7:0] A_TRIG2 = 8'h17;
    localparam logic [7:0] A_DELAY = 8'h18;
    localparam logic [7:0] A_SST0 = 8'h19;
    localparam logic [7:0] A_SST1 = 8'h1A;
    localparam logic [7:0] A_HOST = 8'h30;
    localparam logic [7:0] R_ZERO = 8'h00;
    localparam logic [7:0] R_SLOT = 8'h07;
    localparam logic [7:0] R_TRIG = 8'hC0;
    localparam logic [7:0] R_SST0 = 8'h55;
    localparam int WARN_BIT = 7;
    localparam int FLAG_LSB = 2;
    localparam int SRC_LSB = 6;
    localparam int GOOD_LSB = 3;
    localparam int PIN_LSB = 1;
    localparam int DLY1_LSB = 4;
    localparam int DLY2_LSB = 0;
    localparam int L1SST_BIT = 7;
    localparam int L2SST_BIT = 6;
    localparam int CLK_MHZ = 125;
    localparam int STEP_US = 250;
    localparam int STEP_CYC = STEP_US * CLK_MHZ;
    localparam logic [4:0] LAST_SLOT = 5'h1F;
    localparam logic [1:0] HOST_HIGH = 2'h1;
    // Arbitrary bus address, not tied to any product.
    localparam logic [6:0] I2C_ADDR_DEF = 7'h2A;
    localparam logic [9:0] RAMP_125 = 10'h07D;
    localparam logic [9:0] RAMP_250 = 10'h0FA;
    localparam logic [9:0] RAMP_500 = 10'h1F4;
    localparam logic [9:0] RAMP_750 = 10'h2EE;

    typedef enum logic [1:0] {SRC_GOOD, SRC_PIN, SRC_HOST, SRC_SLOT} pev_src_e;
    typedef struct packed {logic en; logic [7:0] addr; logic [7:0] data;} pev_wr_s;
    typedef struct packed {logic [9:0] b1, b2, b3, b4, l1, l2;} pev_ramp_s;

    function automatic logic [9:0] ramp_us(input logic [1:0] code, input logic ldo);
        if (ldo) begin
            ramp_us = (code == 2'h0) ? RAMP_250 : (code == 2'h1) ? RAMP_500 : 10'h000;
        end else begin
            ramp_us = (code == 2'h0) ? RAMP_125 : (code == 2'h1) ? RAMP_250 :
                      (code == 2'h2) ? RAMP_500 : RAMP_750;
        end
    endfunction
endpackage

/* File: logic/pev_regs.sv */
// Event masking, flag and external enable register bank reached over I2C.
// What this block does
// - Bit 7 picks the input overvoltage warning level, 0 low, 1 high.
// - A set reset-mask bit stops its event from pulling the reset output.
// - Writing one to a clear bit clears the matching latched flag only if its event has already gone.
// - A set interrupt-mask bit stops its event raising the flag.
// - Five-bit slot code, zero off, code n at (n-1) 250 us steps.
// - In a wake-up sequence the output rises itself at its slot.
// - Source field bits 7:6 picks good, pin, host level or slot.
// - Good field bits 5:3 picks a rail, reset output or supply monitor.
// - Pin field bits 2:1 picks one of four enable pins, rising after it.
// - Four-bit delay per output, 250 us steps, before the output rises from any source but host level.
// - Second output has its own slot and trigger registers and its own fields in the delay and host registers, with identical encodings.
// - Buck ramp codes give 125, 250, 500 or 750 us.
// - Buck 4 in linear mode gives 250 or 500 us, others reserved.
// - Linear regulator ramp bits sit at 7 and 6, rest read zero.
// - Linear regulator ramp bit gives 250 us at 0, 500 us at 1.
// - External enables stay low until the reset output is released.
// - Host level code 00 drives low and 01 drives high.
`timescale 1ns/1ps
module pev_regs #(
    parameter int STEP_CYCLES = pev_pkg::STEP_CYC,
    parameter logic [6:0] DEV_ADDR = pev_pkg::I2C_ADDR_DEF
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [5:0] rail_power_bad_i,
    input wire logic input_overvolt_i,
    input wire logic overtemp_i,
    input wire logic [5:0] exception_i,
    input wire logic [5:0] rail_power_good_i,
    input wire logic supply_monitor_ok_i,
    input wire logic [3:0] enable_pin_i,
    input wire logic wake_i,
    input wire logic buck4_ldo_mode_i,
    output logic reset_out_n_o,
    output logic interrupt_out_n_o,
    output logic external_enable_out1_o,
    output logic external_enable_out2_o,
    output logic input_overvolt_warn_level_o,
    output pev_pkg::pev_ramp_s ramp_o
);
    import pev_pkg::*;
    localparam int SW = 28;
    localparam int CW = $clog2(STEP_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    logic [SW-1:0] sync1, sync2;
    logic scl_s, sda_s, wake_s, wake_q, mon_s, vin_ov_s, ot_s;
    logic [3:0] pin_s;
    logic [5:0] pg_s, pb_s, ev_s;
    logic [7:0] fault;

    // Every pin but buck4_ldo_mode_i and rstn_i passes two flops first, as the pins are foreign to this clock.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {scl_i, sda_i, wake_i, enable_pin_i, rail_power_good_i, supply_monitor_ok_i,
                      rail_power_bad_i, input_overvolt_i, overtemp_i, exception_i};
            sync2 <= sync1;
        end
    end

    assign {scl_s, sda_s, wake_s, pin_s, pg_s, mon_s, pb_s, vin_ov_s, ot_s, ev_s} = sync2;
    assign fault = {pb_s[0], pb_s[1], pb_s[2], pb_s[3], pb_s[4], pb_s[5], vin_ov_s, ot_s};

    ////////////////////////////////////////////////////////////////////////
    pev_wr_s wr;
    logic [7:0] ptr, rdata;
    logic [7:0] rst_mask, imask, slot1, slot2, trig1, trig2, delay, sst0, sst1, host;
    logic warn_level;
    logic [5:0] flags, next_flags, clr;

    pev_i2c #(.DEV_ADDR(DEV_ADDR)) u_i2c (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .scl_i(scl_s),
        .sda_i(sda_s),
        .rdata_i(rdata),
        .sda_oe_o(sda_oe_o),
        .ptr_o(ptr),
        .wr_o(wr)
    );

    // The pin is open drain, so the driven level is always low.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warn_level <= 1'b0;
            rst_mask <= R_ZERO;
            imask <= R_ZERO;
        end else if (wr.en) begin
            case (wr.addr)
                A_WARN: warn_level <= wr.data[WARN_BIT];
                A_RSTMASK: rst_mask <= wr.data;
                A_IMASK: imask <= {wr.data[7:FLAG_LSB], 2'b00};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slot1 <= R_SLOT;
            slot2 <= R_SLOT;
            trig1 <= R_TRIG;
            trig2 <= R_TRIG;
            delay <= R_ZERO;
            host <= R_ZERO;
        end else if (wr.en) begin
            case (wr.addr)
                A_SLOT1: slot1 <= {3'b000, wr.data[4:0]};
                A_SLOT2: slot2 <= {3'b000, wr.data[4:0]};
                A_TRIG1: trig1 <= {wr.data[7:1], 1'b0};
                A_TRIG2: trig2 <= {wr.data[7:1], 1'b0};
                A_DELAY: delay <= wr.data;
                A_HOST: host <= {4'h0, wr.data[3:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sst0 <= R_SST0;
            sst1 <= R_ZERO;
        end else if (wr.en && wr.addr == A_SST0) begin
            sst0 <= wr.data;
        end else if (wr.en && wr.addr == A_SST1) begin
            sst1 <= {wr.data[7:6], 6'h00};
        end
    end

    always_comb begin
        case (ptr)
            A_WARN: rdata = {warn_level, 7'h00};
            A_RSTMASK: rdata = rst_mask;
            A_CLR: rdata = {flags, 2'b00};
            A_IMASK: rdata = imask;
            A_SLOT1: rdata = slot1;
            A_SLOT2: rdata = slot2;
            A_TRIG1: rdata = trig1;
            A_TRIG2: rdata = trig2;
            A_DELAY: rdata = delay;
            A_SST0: rdata = sst0;
            A_SST1: rdata = sst1;
            A_HOST: rdata = host;
            default: rdata = R_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // A clear only takes where the event has gone, and a new event wins over it.
    assign clr = (wr.en && wr.addr == A_CLR) ? wr.data[7:FLAG_LSB] : 6'h00;
    assign next_flags = (flags & ~(clr & ~ev_s)) | (ev_s & ~imask[7:FLAG_LSB]);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags <= 6'h00;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            interrupt_out_n_o <= 1'b1;
            reset_out_n_o <= 1'b0;
            input_overvolt_warn_level_o <= 1'b0;
        end else begin
            interrupt_out_n_o <= ~|(flags & ~imask[7:FLAG_LSB]);
            reset_out_n_o <= ~|(fault & ~rst_mask);
            input_overvolt_warn_level_o <= warn_level;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ramp_o <= '0;
        end else begin
            ramp_o.b1 <= ramp_us(sst0[7:6], 1'b0);
            ramp_o.b2 <= ramp_us(sst0[5:4], 1'b0);
            ramp_o.b3 <= ramp_us(sst0[3:2], 1'b0);
            ramp_o.b4 <= ramp_us(sst0[1:0], buck4_ldo_mode_i);
            ramp_o.l1 <= ramp_us({1'b0, sst1[L1SST_BIT]}, 1'b1);
            ramp_o.l2 <= ramp_us({1'b0, sst1[L2SST_BIT]}, 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up schedule: slot n is live from step n-1, one step each 250 us.
    logic [4:0] slot_now;
    logic [CW-1:0] wcyc;
    logic wake_start;
    logic [7:0] good;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_q <= 1'b0;
            wake_start <= 1'b0;
        end else begin
            wake_q <= wake_s;
            wake_start <= wake_s && !wake_q;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slot_now <= 5'h00;
            wcyc <= '0;
        end else if (wake_start) begin
            slot_now <= 5'h01;
            wcyc <= '0;
        end else if (slot_now != 5'h00) begin
            if (wcyc == CW'(STEP_CYCLES - 1)) begin
                wcyc <= '0;
                slot_now <= (slot_now == LAST_SLOT) ? 5'h00 : slot_now + 5'h01;
            end else begin
                wcyc <= wcyc + 1'b1;
            end
        end
    end

    assign good = {mon_s, reset_out_n_o, pg_s};

    // Both outputs wait for the reset output's release before any activity.
    pev_ext_out #(.STEP_CYCLES(STEP_CYCLES)) u_out1 (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .en_i(reset_out_n_o),
        .cfg_i(trig1),
        .slot_i(slot1[4:0]),
        .delay_i(delay[DLY1_LSB+:4]),
        .host_i(host[1:0]),
        .good_i(good),
        .pin_i(pin_s),
        .slot_now_i(slot_now),
        .wake_start_i(wake_start),
        .out_o(external_enable_out1_o)
    );

    pev_ext_out #(.STEP_CYCLES(STEP_CYCLES)) u_out2 (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .en_i(reset_out_n_o),
        .cfg_i(trig2),
        .slot_i(slot2[4:0]),
        .delay_i(delay[DLY2_LSB+:4]),
        .host_i(host[3:2]),
        .good_i(good),
        .pin_i(pin_s),
        .slot_now_i(slot_now),
        .wake_start_i(wake_start),
        .out_o(external_enable_out2_o)
    );

    ////////////////////////////////////////////////////////////////////////
    property p_reset_pull;
        @(posedge clk_i) disable iff (!rstn_i) (|(fault & ~rst_mask)) |=> !reset_out_n_o;
    endproperty
    a_reset_pull: assert property (p_reset_pull) else $error("unmasked fault did not pull reset");

    // The sampled reset term keeps the release edge, where the flop still holds reset, out of the check.
    property p_reset_masked;
        @(posedge clk_i) disable iff (!rstn_i) (rstn_i && (fault & ~rst_mask) == 8'h00) |=> reset_out_n_o;
    endproperty
    a_reset_masked: assert property (p_reset_masked) else $error("masked fault pulled reset");

    property p_clear;
        @(posedge clk_i) disable iff (!rstn_i)
            (wr.en && wr.addr == A_CLR && wr.data[7:2] == 6'h3F && ev_s == 6'h00) |=> flags == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear flags");

    property p_set_wins;
        @(posedge clk_i) disable iff (!rstn_i) (ev_s[0] && !imask[FLAG_LSB]) |=> flags[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("unmasked event lost");

    property p_masked_quiet;
        @(posedge clk_i) disable iff (!rstn_i) (imask[7:2] == 6'h3F && flags == 6'h00) |=> flags == 6'h00;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked event set a flag");

    property p_irq;
        @(posedge clk_i) disable iff (!rstn_i) (flags & ~imask[7:2]) != 6'h00 |=> !interrupt_out_n_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not asserted");

    property p_hold_before_release;
        @(posedge clk_i) disable iff (!rstn_i) !reset_out_n_o |=> !external_enable_out1_o && !external_enable_out2_o;
    endproperty
    a_hold_before_release: assert property (p_hold_before_release) else $error("enable before release");

    property p_host_level;
        @(posedge clk_i) disable iff (!rstn_i)
            (reset_out_n_o && trig1[7:6] == 2'b10 && host[1:0] == 2'b01) |=> external_enable_out1_o;
    endproperty
    a_host_level: assert property (p_host_level) else $error("host level not driven");

    property p_b4_ldo;
        @(posedge clk_i) disable iff (!rstn_i) (buck4_ldo_mode_i && sst0[1:0] == 2'b00) |=> ramp_o.b4 == 10'h0FA;
    endproperty
    a_b4_ldo: assert property (p_b4_ldo) else $error("buck4 linear ramp wrong");

    property p_warn;
        @(posedge clk_i) disable iff (!rstn_i) (wr.en && wr.addr == A_WARN) |=> ##1
            input_overvolt_warn_level_o == $past(wr.data[7], 2);
    endproperty
    a_warn: assert property (p_warn) else $error("warning level not applied");

    property p_flag_hold;
        @(posedge clk_i) disable iff (!rstn_i) (flags[0] && ev_s[0]) |=> flags[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared while event present");

    property p_linreg_ramp;
        @(posedge clk_i) disable iff (!rstn_i) sst1[L1SST_BIT] |=> ramp_o.l1 == RAMP_500;
    endproperty
    a_linreg_ramp: assert property (p_linreg_ramp) else $error("linear regulator ramp wrong");

    c_slot_rise: cover property (@(posedge clk_i) disable iff (!rstn_i)
        trig1[7:6] == 2'b11 ##1 $rose(external_enable_out1_o));
    c_flag: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(flags[0]));
    c_pin_rise: cover property (@(posedge clk_i) disable iff (!rstn_i)
        trig2[7:6] == 2'b01 ##1 $rose(external_enable_out2_o));
    c_host_rise: cover property (@(posedge clk_i) disable iff (!rstn_i)
        trig1[7:6] == 2'b10 ##1 $rose(external_enable_out1_o));
endmodule
